/* pmr_pkg.sv */
// Constants and types shared by both ends of the power/mode link.
// Assumes one 25 MHz master clock feeds device and host.
//
// Operation
// - Held disabled until digital supply valid
// - Rails and references good, then ordered power-up
// - Power enable bit switches whole device
// - Powered down keeps registers, serial port live
// - Host restarts power enable before configuring
// - LED supply loss keeps configuration
// - Host writes mode codes to setup one
// - Master clock to strobe ratio per mode
// - Mode two dual sampling writes 03 to setup three
// - Key A3 at 01 enters test mode
// - Test mode maps every address to page
// - Test read of 27 returns revision
// - Key 23 at 01 leaves test mode
// - Write frame: address, data, commit strobe
// - Read frame returns data on falling clock
package pmr_pkg;

  // ==========================================================
  // Serial frame
  localparam int          FRAME_W        = 14;
  localparam int          READ_BIT       = 4;
  localparam logic [5:0]  ADDR_SETUP1    = 6'h01;
  localparam logic [5:0]  ADDR_SETUP2    = 6'h02;
  localparam logic [5:0]  ADDR_SETUP3    = 6'h03;
  localparam logic [5:0]  ADDR_SWRESET   = 6'h04;
  localparam logic [5:0]  ADDR_REVISION  = 6'h27;
  localparam logic [7:0]  TEST_ENTER_KEY = 8'hA3;
  localparam logic [7:0]  TEST_EXIT_KEY  = 8'h23;

  // ==========================================================
  // Setup registers
  localparam logic [7:0]  SETUP1_RST     = 8'h03;
  localparam logic [7:0]  SETUP2_RST     = 8'h00;
  localparam logic [7:0]  SETUP3_RST     = 8'h13;
  localparam int          EN_BIT         = 0;
  localparam int          DUAL_BIT       = 1;
  localparam int          MAX_SPEED_BIT  = 6;
  localparam int          DUAL_REF_LSB   = 4;
  localparam logic [7:0]  MODE1_DUAL     = 8'h0F;
  localparam logic [7:0]  MODE12_SINGLE  = 8'h0D;
  localparam logic [7:0]  MODE3_SINGLE   = 8'h4D;
  localparam logic [7:0]  SETUP3_M2_DUAL = 8'h03;

  // ==========================================================
  // Sampling ratios
  localparam logic [7:0]  RATIO_MODE2    = 8'h03;
  localparam logic [7:0]  RATIO_MODE3    = 8'h02;
  localparam logic [7:0]  RATIO_M1_MIN   = 8'h04;

  // ==========================================================
  // Timing
  localparam int          CLK_NS         = 40;
  localparam int          STAGE_NS       = 200;
  localparam logic [3:0]  STAGE_CYC      =
    4'((STAGE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  SCK_HALF       = 5'h0A;

  // ==========================================================
  // Host APB map
  localparam logic [7:0]  HOST_CMD       = 8'h00;
  localparam logic [7:0]  HOST_STATUS    = 8'h04;
  localparam logic [7:0]  HOST_MODE      = 8'h08;
  localparam int          CMD_ADDR_LSB   = 8;
  localparam int          ST_INIT_BIT    = 1;
  localparam int          ST_RDATA_LSB   = 8;
  localparam int          MODE_DUAL_BIT  = 2;
  localparam int          MODE_N_LSB     = 4;

  typedef enum logic [2:0] {
    PWR_POR, PWR_LDO, PWR_REFS, PWR_SEQ, PWR_ON, PWR_OFF
  } pmr_pwr_t;

  typedef enum logic [2:0] {
    H_IDLE, H_SHIFT, H_COMMIT, H_READ, H_GAP
  } pmr_host_t;

endpackage : pmr_pkg

/* pmr_link_if.sv */
// Four-wire control link plus pixel sample strobe.
// Assumes both ends share the master clock.
`timescale 1ns/1ps
`default_nettype none
interface pmr_link_if;
  logic sck;
  logic serial_data_in;
  logic serial_commit_strobe;
  logic serial_data_out;
  logic pixel_sample_strobe;

  modport device (
    input  sck,
    input  serial_data_in,
    input  serial_commit_strobe,
    input  pixel_sample_strobe,
    output serial_data_out
  );

  modport host (
    output sck,
    output serial_data_in,
    output serial_commit_strobe,
    output pixel_sample_strobe,
    input  serial_data_out
  );
endinterface : pmr_link_if
`default_nettype wire

/* pmr_device.sv */
// Device end: power sequencing, setup registers, test page.
// Assumes link pins are asynchronous to clk; strobe is on clk.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmr_device #(
  // Arbitrary value
  parameter logic [6:0] REVISION = 7'h2A
) (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  ce,
  pmr_link_if.device link,
  input  wire logic  digital_supply_ok,
  input  wire logic  led_drive_supply_ok,
  input  wire logic  front_end_supply_ok,
  input  wire logic  references_ok,
  output logic       ldo_enable,
  output logic       reference_enable,
  output logic       system_enable,
  output logic       device_active,
  output logic       test_mode,
  output logic       dual_sample_mode,
  output logic       max_speed_mode,
  output logic       ratio_ok
);
  import pmr_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [6:0]   raw;
  logic [6:0]   s1_q;
  logic [6:0]   s2_q;

  assign raw = {link.sck, link.serial_data_in, link.serial_commit_strobe, digital_supply_ok,
                led_drive_supply_ok, front_end_supply_ok,
                references_ok};

  for (genvar i = 0; i < 7; i++) begin : g_sync
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else if (ce) begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  logic sck_s;
  logic sdi_s;
  logic sen_s;
  logic dig_s;
  logic led_s;
  logic fe_s;
  logic ref_s;
  logic por;

  assign sck_s = s2_q[6];
  assign sdi_s = s2_q[5];
  assign sen_s = s2_q[4];
  assign dig_s = s2_q[3];
  assign led_s = s2_q[2];
  assign fe_s  = s2_q[1];
  assign ref_s = s2_q[0];
  assign por   = ~dig_s;

  // ==========================================================
  // Serial edges and shifter
  logic               sck_prev_q;
  logic               sen_prev_q;
  logic [FRAME_W-1:0] shift_q;
  logic               sck_rise;
  logic               sck_fall;
  logic               commit;
  logic [5:0]         frame_addr;
  logic [7:0]         frame_data;
  logic               is_read;

  assign sck_rise   = sck_s & ~sck_prev_q;
  assign sck_fall   = ~sck_s & sck_prev_q;
  assign commit     = sen_s & ~sen_prev_q;
  assign frame_addr = shift_q[FRAME_W-1:8];
  assign frame_data = shift_q[7:0];
  assign is_read    = frame_addr[READ_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_prev_q <= 1'b0;
      sen_prev_q <= 1'b0;
    end else if (ce) begin
      sck_prev_q <= sck_s;
      sen_prev_q <= sen_s;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= '0;
    end else if (ce && sck_rise) begin
      shift_q <= {shift_q[FRAME_W-2:0], sdi_s};
    end
  end

  // ==========================================================
  // Setup registers
  logic [7:0] setup1_q;
  logic [7:0] setup2_q;
  logic [7:0] setup3_q;
  logic       test_q;
  logic       wr;

  assign wr = commit & ~is_read;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setup1_q <= SETUP1_RST;
      setup2_q <= SETUP2_RST;
      setup3_q <= SETUP3_RST;
    end else if (ce) begin
      if (por) begin
        setup1_q <= SETUP1_RST;
        setup2_q <= SETUP2_RST;
        setup3_q <= SETUP3_RST;
      end else if (wr && !test_q) begin
        // Decoded in every power state
        if (frame_addr == ADDR_SWRESET) begin
          setup1_q <= SETUP1_RST;
          setup2_q <= SETUP2_RST;
          setup3_q <= SETUP3_RST;
        end else if (frame_addr == ADDR_SETUP1 &&
                     frame_data != TEST_ENTER_KEY) begin
          setup1_q <= frame_data;
        end else if (frame_addr == ADDR_SETUP2) begin
          setup2_q <= frame_data;
        end else if (frame_addr == ADDR_SETUP3) begin
          setup3_q <= frame_data;
        end
      end
    end
  end

  // Test page mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      test_q <= 1'b0;
    end else if (ce) begin
      if (por) begin
        test_q <= 1'b0;
      end else if (wr && test_q) begin
        if (frame_data == TEST_EXIT_KEY) begin
          test_q <= 1'b0;
        end
      end else if (wr) begin
        if (frame_addr == ADDR_SETUP1 &&
            frame_data == TEST_ENTER_KEY) begin
          test_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Read-back
  function automatic logic [7:0] read_value(
    input logic [5:0] addr,
    input logic       tst,
    input logic [7:0] r1,
    input logic [7:0] r2,
    input logic [7:0] r3
  );
    logic [5:0] a;
    a = addr;
    a[READ_BIT] = 1'b0;
    if (tst) begin
      read_value = {REVISION, 1'b0};
    end else if (a == ADDR_SETUP1) begin
      read_value = r1;
    end else if (a == ADDR_SETUP2) begin
      read_value = r2;
    end else if (a == ADDR_SETUP3) begin
      read_value = r3;
    end else begin
      read_value = 8'h00;
    end
  endfunction : read_value

  logic [7:0] out_q;
  logic       sdo_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q <= 8'h00;
      sdo_q <= 1'b0;
    end else if (ce) begin
      if (commit && is_read) begin
        out_q <= read_value(frame_addr, test_q, setup1_q,
                            setup2_q, setup3_q);
      end else if (sck_fall) begin
        sdo_q <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  assign link.serial_data_out = sdo_q;

  // ==========================================================
  // Power sequencer
  pmr_pwr_t   state_q;
  pmr_pwr_t   state_d;
  logic [3:0] stage_q;
  logic       en;
  logic       rails;

  assign en    = setup1_q[EN_BIT];
  assign rails = led_s & fe_s & ref_s;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PWR_POR:  state_d = PWR_LDO;
      PWR_LDO:  if (led_s) state_d = PWR_REFS;
      PWR_REFS: if (rails) state_d = PWR_SEQ;
      PWR_SEQ: begin
        if (!rails) state_d = PWR_LDO;
        else if (stage_q == STAGE_CYC) state_d = PWR_ON;
      end
      PWR_ON:   if (!rails) state_d = PWR_LDO;
      PWR_OFF:  if (en) state_d = PWR_LDO;
      default:  state_d = PWR_POR;
    endcase
    if (!en && state_d != PWR_POR) begin
      state_d = PWR_OFF;
    end
    if (por) begin
      state_d = PWR_POR;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q          <= PWR_POR;
      stage_q          <= 4'h0;
      ldo_enable       <= 1'b0;
      reference_enable <= 1'b0;
      system_enable    <= 1'b0;
      device_active    <= 1'b0;
    end else if (ce) begin
      state_q          <= state_d;
      stage_q          <= (state_d == PWR_SEQ && state_q == PWR_SEQ)
                          ? stage_q + 4'h1 : 4'h0;
      ldo_enable       <= state_d != PWR_POR && state_d != PWR_OFF;
      reference_enable <= state_d == PWR_REFS || state_d == PWR_SEQ
                          || state_d == PWR_ON;
      system_enable    <= state_d == PWR_SEQ || state_d == PWR_ON;
      device_active    <= state_d == PWR_ON;
    end
  end

  // ==========================================================
  // Strobe ratio monitor
  logic [7:0] gap_q;
  logic [7:0] gap_n;
  logic       ratio_q;

  assign gap_n = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_q   <= 8'h00;
      ratio_q <= 1'b0;
    end else if (ce) begin
      if (link.pixel_sample_strobe) begin
        gap_q <= 8'h00;
        if (setup1_q[MAX_SPEED_BIT]) begin
          ratio_q <= gap_n == RATIO_MODE3;
        end else begin
          ratio_q <= gap_n == RATIO_MODE2 ||
                     (gap_n >= RATIO_M1_MIN && !gap_n[0]);
        end
      end else begin
        gap_q <= gap_n;
      end
    end
  end

  assign test_mode        = test_q;
  assign dual_sample_mode = setup1_q[DUAL_BIT];
  assign max_speed_mode   = setup1_q[MAX_SPEED_BIT];
  assign ratio_ok         = ratio_q;

endmodule : pmr_device
`default_nettype wire

/* pmr_host.sv */
// Host end: APB-controlled serial master and strobe source.
// Assumes supplies_up and link.sdo are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pmr_host (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  ce,
  input  wire logic  psel,
  input  wire logic  penable,
  input  wire logic  pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic       pready,
  output logic       pslverr,
  input  wire logic  supplies_up,
  pmr_link_if.host   link
);
  import pmr_pkg::*;

  // ==========================================================
  // Synchronisers
  logic [1:0] s1_q;
  logic [1:0] s2_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= 2'b00;
      s2_q <= 2'b00;
    end else if (ce) begin
      s1_q <= {supplies_up, link.serial_data_out};
      s2_q <= s1_q;
    end
  end

  // ==========================================================
  // APB slave
  logic [13:0] cmd_q;
  logic        cmd_pend_q;
  logic [7:0]  mode_q;
  logic        mode_pend_q;
  logic [7:0]  rdata_q;
  logic [1:0]  init_q;
  logic        busy;
  logic        acc;
  logic        launch_cmd;
  logic        launch_mode;

  assign acc = psel & penable & pready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable;
      if (psel && !penable && !pwrite) begin
        if (paddr == HOST_STATUS) begin
          prdata <= {16'h0000, rdata_q, 6'h00,
                     init_q[1], busy};
        end else if (paddr == HOST_MODE) begin
          prdata <= {24'h000000, mode_q};
        end else if (paddr == HOST_CMD) begin
          prdata <= {18'h00000, cmd_q};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q       <= '0;
      cmd_pend_q  <= 1'b0;
      mode_q      <= 8'h00;
      mode_pend_q <= 1'b0;
    end else if (ce) begin
      if (acc && pwrite && paddr == HOST_CMD && !cmd_pend_q) begin
        cmd_q      <= {pwdata[CMD_ADDR_LSB +: 6], pwdata[7:0]};
        cmd_pend_q <= 1'b1;
      end else if (launch_cmd) begin
        cmd_pend_q <= 1'b0;
      end
      if (acc && pwrite && paddr == HOST_MODE && !mode_pend_q) begin
        mode_q      <= pwdata[7:0];
        mode_pend_q <= 1'b1;
      end else if (launch_mode) begin
        mode_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Frame selection
  pmr_host_t   st_q;
  logic [13:0] frame;
  logic        go;
  logic        m2dual_q;
  logic        m2dual;
  logic [7:0]  mode_code;

  assign m2dual = mode_q[1:0] == 2'd2 && mode_q[MODE_DUAL_BIT];
  assign mode_code = (mode_q[1:0] == 2'd3) ? MODE3_SINGLE :
                     mode_q[MODE_DUAL_BIT] ? MODE1_DUAL :
                     MODE12_SINGLE;
  assign go = st_q == H_IDLE;
  assign launch_mode = go && init_q == 2'd2 && mode_pend_q
                       && !m2dual_q;
  assign launch_cmd  = go && init_q == 2'd2 && !mode_pend_q
                       && !m2dual_q && cmd_pend_q;
  assign busy = cmd_pend_q;

  always_comb begin
    if (init_q == 2'd0) begin
      frame = {ADDR_SETUP1, SETUP1_RST & 8'hFE};
    end else if (init_q == 2'd1) begin
      frame = {ADDR_SETUP1, SETUP1_RST};
    end else if (m2dual_q) begin
      frame = {ADDR_SETUP3, SETUP3_M2_DUAL};
    end else if (mode_pend_q) begin
      frame = {ADDR_SETUP1, mode_code};
    end else begin
      frame = cmd_q;
    end
  end

  // ==========================================================
  // Serial engine
  logic [4:0]  half_q;
  logic [3:0]  bit_q;
  logic [13:0] sh_q;
  logic        rd_q;
  logic        tick;
  logic        start;

  assign tick  = half_q == SCK_HALF - 5'd1;
  assign start = go && (init_q != 2'd2 ? s2_q[1]
                 : (m2dual_q || mode_pend_q || cmd_pend_q));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q     <= H_IDLE;
      half_q   <= 5'd0;
      bit_q    <= 4'd0;
      sh_q     <= '0;
      rd_q     <= 1'b0;
      rdata_q  <= 8'h00;
      init_q   <= 2'd0;
      m2dual_q <= 1'b0;
      link.sck <= 1'b0;
      link.serial_data_in <= 1'b0;
      link.serial_commit_strobe <= 1'b0;
    end else if (ce) begin
      half_q <= (go || tick) ? 5'd0 : half_q + 5'd1;
      case (st_q)
        H_IDLE: if (start) begin
          st_q     <= H_SHIFT;
          sh_q     <= {frame[12:0], 1'b0};
          link.serial_data_in <= frame[13];
          rd_q     <= frame[8 + READ_BIT];
          bit_q    <= 4'd0;
          if (init_q != 2'd2) init_q <= init_q + 2'd1;
          if (m2dual_q) m2dual_q <= 1'b0;
          else if (launch_mode) m2dual_q <= m2dual;
        end
        H_SHIFT: if (tick) begin
          link.sck <= ~link.sck;
          if (link.sck) begin
            link.serial_data_in <= sh_q[13];
            sh_q     <= {sh_q[12:0], 1'b0};
            bit_q    <= bit_q + 4'd1;
            if (bit_q == 4'd13) begin
              st_q     <= H_COMMIT;
              link.serial_commit_strobe <= 1'b1;
            end
          end
        end
        H_COMMIT: if (tick) begin
          link.serial_commit_strobe <= 1'b0;
          link.serial_data_in <= 1'b0;
          bit_q    <= 4'd0;
          st_q     <= rd_q ? H_READ : H_GAP;
          link.sck <= rd_q;
        end
        H_READ: if (tick) begin
          link.sck <= ~link.sck;
          if (!link.sck) begin
            rdata_q <= {rdata_q[6:0], s2_q[0]};
            bit_q   <= bit_q + 4'd1;
            if (bit_q == 4'd7) begin
              st_q     <= H_GAP;
              link.sck <= 1'b0;
            end
          end
        end
        H_GAP:   if (tick) st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pixel sample strobe
  logic [7:0] ratio;
  logic [7:0] sc_q;
  logic [7:0] n2;

  assign n2 = (mode_q[7:MODE_N_LSB] < 4'd2) ? RATIO_M1_MIN
              : {3'b000, mode_q[7:MODE_N_LSB], 1'b0};
  assign ratio = (mode_q[1:0] == 2'd3) ? RATIO_MODE3 :
                 (mode_q[1:0] == 2'd2) ? RATIO_MODE2 : n2;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sc_q <= 8'h00;
      link.pixel_sample_strobe <= 1'b0;
    end else if (ce) begin
      sc_q <= (sc_q >= ratio - 8'h01) ? 8'h00 : sc_q + 8'h01;
      link.pixel_sample_strobe <= sc_q >= ratio - 8'h01;
    end
  end

endmodule : pmr_host
`default_nettype wire

/* pmr_link_chk.sv */
// Checker for the serial link and power outputs of the device end.
// Assumes instantiation in the bench beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module pmr_link_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic serial_data_in,
  input wire logic serial_commit_strobe,
  input wire logic serial_data_out,
  input wire logic digital_supply_ok,
  input wire logic references_ok,
  input wire logic system_enable,
  input wire logic device_active,
  input wire logic test_mode,
  input wire logic dual_sample_mode,
  input wire logic max_speed_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Properties
  a_por_disables: assert property (
    !digital_supply_ok [*6] |-> !system_enable && !test_mode)
    else $error("enabled without digital supply");
  a_refs_gate_enable: assert property (
    !references_ok [*6] |-> !system_enable)
    else $error("enabled without references");
  a_active_after_enable: assert property (
    $rose(device_active) |-> $past(system_enable, 4))
    else $error("active before ordered power-up");
  a_sdi_held_high: assert property (
    sck && $past(sck) |-> $stable(serial_data_in))
    else $error("data moved while serial clock high");
  a_commit_clock_low: assert property (
    serial_commit_strobe |-> !sck)
    else $error("commit strobe with serial clock high");
  a_sck_high_width: assert property (
    $rose(sck) |-> sck [*8])
    else $error("serial clock high phase too short");
  a_sdo_held_high: assert property (
    sck |-> $stable(serial_data_out))
    else $error("read data moved while serial clock high");
  a_config_held: assert property (
    (digital_supply_ok && !serial_commit_strobe) [*5]
      |-> $stable(dual_sample_mode) && $stable(max_speed_mode))
    else $error("configuration changed without a commit");
  a_test_entry_commit: assert property (
    $rose(test_mode) |-> serial_commit_strobe)
    else $error("test mode entered without a commit");
  a_test_exit_commit: assert property (
    $fell(test_mode) |-> serial_commit_strobe || !$past(digital_supply_ok, 2)
      || !$past(digital_supply_ok, 4))
    else $error("test mode left without a commit");
endmodule : pmr_link_chk
`default_nettype wire

/* test_power_mode_revision_ctrl.sv */
// Bench: host and device joined by the link, host driven over APB.
// Assumes package, interface, both ends and checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_revision_ctrl;
  import pmr_pkg::*;
  localparam logic [6:0] REV = 7'h35; // Arbitrary value
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        supplies_up = 1'b0;
  logic        dig_ok = 1'b0;
  logic        led_ok = 1'b0;
  logic        fe_ok = 1'b0;
  logic        refs_ok = 1'b0;
  logic        sys_en;
  logic        active;
  logic        tst;
  logic        dual;
  logic        max_spd;
  logic        ratio_ok;
  logic        ldo_en;
  logic        ref_en;
  logic        slverr;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [31:0] q;
  logic [7:0]  mw [4] = '{8'h25, 8'h31, 8'h06, 8'h03};
  logic [7:0]  s1 [4] =
    '{MODE1_DUAL, MODE12_SINGLE, MODE1_DUAL, MODE3_SINGLE};

  always #20 clk = ~clk;

  pmr_link_if pmr_link_if_inst ();
  pmr_device #(.REVISION(REV)) pmr_device_inst (
    .clk(clk), .reset(reset), .ce(1'b1), .link(pmr_link_if_inst),
    .digital_supply_ok(dig_ok), .led_drive_supply_ok(led_ok),
    .front_end_supply_ok(fe_ok), .references_ok(refs_ok),
    .ldo_enable(ldo_en), .reference_enable(ref_en),
    .system_enable(sys_en),
    .device_active(active), .test_mode(tst),
    .dual_sample_mode(dual), .max_speed_mode(max_spd),
    .ratio_ok(ratio_ok));
  pmr_host pmr_host_inst (
    .clk(clk), .reset(reset), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slverr),
    .supplies_up(supplies_up), .link(pmr_link_if_inst));
  pmr_link_chk pmr_link_chk_inst (
    .clk(clk), .reset(reset), .sck(pmr_link_if_inst.sck),
    .serial_data_in(pmr_link_if_inst.serial_data_in), .serial_commit_strobe(pmr_link_if_inst.serial_commit_strobe),
    .serial_data_out(pmr_link_if_inst.serial_data_out), .digital_supply_ok(dig_ok),
    .references_ok(refs_ok), .system_enable(sys_en),
    .device_active(active), .test_mode(tst),
    .dual_sample_mode(dual), .max_speed_mode(max_spd));

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, HOST_CMD, {18'h0, a, d}, r);
    do apb(1'b0, HOST_STATUS, 32'h0, r); while (r[0] !== 1'b0);
    repeat (480) @(posedge clk);
  endtask : frame

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [31:0] r;
    frame(a | 6'h10, 8'h00);
    apb(1'b0, HOST_STATUS, 32'h0, r);
    check({24'h0, r[15:8]}, {24'h0, exp});
  endtask : rd

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // Tests
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    check(active, 1'b0);
    check(sys_en, 1'b0);
    check(ldo_en, 1'b0);
    dig_ok <= 1'b1;
    repeat (20) @(posedge clk);
    check(sys_en, 1'b0);
    check(ldo_en, 1'b1);
    check(ref_en, 1'b0);
    led_ok <= 1'b1;
    fe_ok <= 1'b1;
    refs_ok <= 1'b1;
    supplies_up <= 1'b1;
    do apb(1'b0, HOST_STATUS, 32'h0, q); while (q[ST_INIT_BIT] !== 1'b1);
    check(slverr, 1'b0);
    repeat (500) @(posedge clk);
    check(active, 1'b1);
    rd(ADDR_SETUP1, SETUP1_RST);
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, HOST_MODE, {24'h0, mw[i]}, q);
      repeat (1000) @(posedge clk);
      check(dual, s1[i][DUAL_BIT]);
      check(max_spd, s1[i][MAX_SPEED_BIT]);
      check(ratio_ok, 1'b1);
      rd(ADDR_SETUP1, s1[i]);
    end
    rd(ADDR_SETUP3, SETUP3_M2_DUAL);
    apb(1'b0, HOST_MODE, 32'h0, q);
    check(q, {24'h0, mw[3]});
    frame(ADDR_SWRESET, 8'h00);
    rd(ADDR_SETUP3, SETUP3_RST);
    check(ratio_ok, 1'b0);
    $display("test modes done");
    frame(ADDR_SETUP1, 8'h4C);
    check(active, 1'b0);
    check(ldo_en, 1'b0);
    rd(ADDR_SETUP1, 8'h4C);
    frame(ADDR_SETUP1, MODE1_DUAL);
    check(active, 1'b1);
    check(dual, 1'b1);
    led_ok <= 1'b0;
    repeat (20) @(posedge clk);
    check(active, 1'b0);
    check(ref_en, 1'b0);
    check(ldo_en, 1'b1);
    rd(ADDR_SETUP1, MODE1_DUAL);
    led_ok <= 1'b1;
    repeat (20) @(posedge clk);
    check(active, 1'b1);
    refs_ok <= 1'b0;
    repeat (20) @(posedge clk);
    check(sys_en, 1'b0);
    refs_ok <= 1'b1;
    repeat (20) @(posedge clk);
    check(active, 1'b1);
    $display("test power control done");
    frame(ADDR_SETUP1, TEST_ENTER_KEY);
    check(tst, 1'b1);
    check(dual, 1'b1);
    rd(ADDR_REVISION, {REV, 1'b0});
    rd(ADDR_SETUP2, {REV, 1'b0});
    frame(ADDR_SETUP1, TEST_EXIT_KEY);
    check(tst, 1'b0);
    rd(ADDR_REVISION, 8'h00);
    $display("test revision page done");
    frame(ADDR_SETUP1, MODE3_SINGLE);
    dig_ok <= 1'b0;
    repeat (20) @(posedge clk);
    check(active, 1'b0);
    check(max_spd, 1'b0);
    dig_ok <= 1'b1;
    repeat (100) @(posedge clk);
    check(active, 1'b1);
    check(dual, SETUP1_RST[DUAL_BIT]);
    $display("test supply loss done");
    complete_run();
  end
endmodule : test_power_mode_revision_ctrl
`default_nettype wire
